// File: inc/agia_cfg.svh
// Constants of the converter gain access block: offsets, resets, fields.
// Assumes inclusion by bare name from the inc/ folder.
`ifndef AGIA_CFG_SVH
`define AGIA_CFG_SVH

// ----------------------------------------------------------------
// Special function register addresses
// ----------------------------------------------------------------
`define AGIA_CFG_ADDR 8'hec
`define AGIA_RES_HIGH_ADDR 8'hbe
`define AGIA_RES_LOW_ADDR 8'hbd

// ----------------------------------------------------------------
// Indirect gain register addresses
// ----------------------------------------------------------------
`define AGIA_GAIN_HIGH_IDX 8'h04
`define AGIA_GAIN_LOW_IDX 8'h07
`define AGIA_GAIN_EXTRA_IDX 8'h08

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AGIA_CFG_RST 8'hf8
`define AGIA_GAIN_HIGH_RST 8'hfc
`define AGIA_GAIN_LOW_RST 4'h0
`define AGIA_GAIN_EXTRA_RST 1'h1
`define AGIA_RES_RST 8'h00
`define AGIA_IDX_RST 8'h00
`define AGIA_EFF_RST 13'h1000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AGIA_GAIN_EN_BIT 0
`define AGIA_LOW_FIELD_MSB 7
`define AGIA_LOW_FIELD_LSB 4
`define AGIA_EXTRA_BIT 0

// ----------------------------------------------------------------
// Gain arithmetic: numerator over 4096, extra bit worth 64/4096
// ----------------------------------------------------------------
`define AGIA_EXTRA_WEIGHT 13'h0040
`define AGIA_GAIN_MAX 13'h103f

`endif

// File: inc/agia_pkg.sv
// Types of the converter gain access block.
// Assumes agia_cfg.svh is reachable on the include path.
package agia_pkg;

    // Which gain register an indirect address selects
    typedef enum logic [1:0] {
        AGIA_SEL_NONE,
        AGIA_SEL_HIGH,
        AGIA_SEL_LOW,
        AGIA_SEL_EXTRA
    } agia_sel_t;

    typedef logic [11:0] agia_word_t;

endpackage

// File: inc/agia_gain_if.sv
// Carrier between the register front end and the gain register store.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps

interface agia_gain_if;
    import agia_pkg::*;

    logic wr;
    agia_sel_t sel;
    logic [7:0] data;
    logic [7:0] high;
    logic [3:0] low;
    logic extra;

    // Front end issues writes, reads back the stored gain
    modport front (output wr, output sel, output data, input high, input low, input extra);
    // Store takes writes, shows its contents
    modport store (input wr, input sel, input data, output high, output low, output extra);
endinterface

// File: hw/agia_gain_regs.sv
// Store of the three write-only gain registers.
// Assumes writes arrive already decoded and qualified by the front end.
`timescale 1ns/10ps
`include "agia_cfg.svh"

module agia_gain_regs
    import agia_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    agia_gain_if.store gif
);

    logic [7:0] high_ff;
    logic [3:0] low_ff;
    logic extra_ff;

    // ----------------------------------------------------------------
    // Gain storage
    // ----------------------------------------------------------------

    // Upper eight gain bits
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            high_ff <= `AGIA_GAIN_HIGH_RST;
        end else if (gif.wr && gif.sel == AGIA_SEL_HIGH) begin
            high_ff <= gif.data; // R9
        end
    end

    // Lower four gain bits, reserved bits dropped
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            low_ff <= `AGIA_GAIN_LOW_RST;
        end else if (gif.wr && gif.sel == AGIA_SEL_LOW) begin
            low_ff <= gif.data[`AGIA_LOW_FIELD_MSB:`AGIA_LOW_FIELD_LSB]; // R10
        end
    end

    // Extra sixty-fourth bit, set after reset
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            extra_ff <= `AGIA_GAIN_EXTRA_RST; // R13
        end else if (gif.wr && gif.sel == AGIA_SEL_EXTRA) begin
            extra_ff <= gif.data[`AGIA_EXTRA_BIT]; // R12
        end
    end

    assign gif.high = high_ff;
    assign gif.low = low_ff;
    assign gif.extra = extra_ff;

endmodule

// File: hw/agia_top.sv
// Gain setting front end of a 12-bit converter, on its special function
// register port. Assumes the processor gives one-cycle read and write strobes.
//
// What this block does and what software must do
// R1: The gain word is the high byte followed by bits 7..4 of the low register.
// R2: The equivalent gain spans zero to about 1.016.
// R3: Effective gain is the word over 4096 plus one sixty-fourth when the extra bit is set.
// R4: While the enable bit of the config register is set, result writes go to the gain store.
// R5: In gain access a result-high write picks the address and a result-low write the data.
// R6: The gain registers cannot be read back.
// R7: Software sets enable, writes address, writes data, then clears enable.
// R8: Software starts no conversion while the enable bit is set.
// R9: Indirect address 0x04 is the high byte, reset 0xfc.
// R10: Indirect address 0x07 holds the lower four bits in bits 7..4, reset zero.
// R11: Software writes zeros to bits 3..0 of the low register.
// R12: Indirect address 0x08 holds the extra sixty-fourth bit in bit 0.
// R13: The extra bit resets to one and its reserved bits to zero.
`timescale 1ns/10ps
`include "agia_cfg.svh"

module agia_top
    import agia_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic conv_done_i,
    input wire logic [15:0] conv_result_i,
    output agia_word_t gain_word_o,
    output logic extra_sixtyfourth_bit_o,
    output logic [12:0] effective_gain_o,
    output logic gain_access_enable_o
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    agia_gain_if gif ();

    logic [7:0] converter_config_register_ff;
    logic [7:0] result_high_register_ff;
    logic [7:0] result_low_register_ff;
    logic [7:0] gain_addr_ff;
    logic [7:0] rdata_ff;
    logic [12:0] effective_gain_ff;
    logic gain_access_enable;
    logic cfg_wr;
    logic res_high_wr;
    logic res_low_wr;

    // Indirect address decode, used by the write path only
    function automatic agia_sel_t agia_decode(input logic [7:0] idx);
        case (idx)
            `AGIA_GAIN_HIGH_IDX: agia_decode = AGIA_SEL_HIGH;
            `AGIA_GAIN_LOW_IDX: agia_decode = AGIA_SEL_LOW;
            `AGIA_GAIN_EXTRA_IDX: agia_decode = AGIA_SEL_EXTRA;
            default: agia_decode = AGIA_SEL_NONE;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Write strobes
    // ----------------------------------------------------------------

    // Per-register write strobes
    assign cfg_wr = sfr_wr_i && sfr_addr_i == `AGIA_CFG_ADDR;
    assign res_high_wr = sfr_wr_i && sfr_addr_i == `AGIA_RES_HIGH_ADDR;
    assign res_low_wr = sfr_wr_i && sfr_addr_i == `AGIA_RES_LOW_ADDR;
    assign gain_access_enable = converter_config_register_ff[`AGIA_GAIN_EN_BIT];

    // Configuration register, bit 0 opens gain access
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            converter_config_register_ff <= `AGIA_CFG_RST;
        end else if (cfg_wr) begin
            converter_config_register_ff <= sfr_wdata_i;
        end
    end

    // Result high: conversion data, or normal write outside gain access
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            result_high_register_ff <= `AGIA_RES_RST;
        end else if (res_high_wr && !gain_access_enable) begin
            result_high_register_ff <= sfr_wdata_i;
        end else if (conv_done_i) begin
            result_high_register_ff <= conv_result_i[15:8];
        end
    end

    // Result low: conversion data, or normal write outside gain access
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            result_low_register_ff <= `AGIA_RES_RST;
        end else if (res_low_wr && !gain_access_enable) begin
            result_low_register_ff <= sfr_wdata_i;
        end else if (conv_done_i) begin
            result_low_register_ff <= conv_result_i[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Indirect gain access
    // ----------------------------------------------------------------

    // Indirect address latched from result-high writes in gain access
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gain_addr_ff <= `AGIA_IDX_RST;
        end else if (res_high_wr && gain_access_enable) begin
            gain_addr_ff <= sfr_wdata_i; // R4 R5
        end
    end

    // Data write to the addressed gain register
    assign gif.wr = res_low_wr && gain_access_enable; // R4 R5
    assign gif.sel = agia_decode(gain_addr_ff); // R9 R10 R12
    assign gif.data = sfr_wdata_i;

    agia_gain_regs u_regs (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .gif(gif.store)
    );

    // ----------------------------------------------------------------
    // Gain outputs
    // ----------------------------------------------------------------

    // Gain word and extra bit straight from the store
    assign gain_word_o = {gif.high, gif.low}; // R1
    assign extra_sixtyfourth_bit_o = gif.extra;
    assign gain_access_enable_o = gain_access_enable;

    // Effective gain numerator over 4096
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            effective_gain_ff <= `AGIA_EFF_RST;
        end else begin
            effective_gain_ff <= {1'b0, gif.high, gif.low}
                + (gif.extra ? `AGIA_EXTRA_WEIGHT : 13'h0000); // R2 R3
        end
    end
    assign effective_gain_o = effective_gain_ff;

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------

    // Registered read data; gain store never on this path
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_ff <= 8'h00;
        end else if (sfr_rd_i) begin
            case (sfr_addr_i)
                `AGIA_CFG_ADDR: rdata_ff <= converter_config_register_ff;
                `AGIA_RES_HIGH_ADDR: rdata_ff <= result_high_register_ff; // R6
                `AGIA_RES_LOW_ADDR: rdata_ff <= result_low_register_ff; // R6
                default: rdata_ff <= 8'h00;
            endcase
        end
    end
    assign sfr_rdata_o = rdata_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    // Gain access steps: address then data
    sequence addr_step_s;
        res_high_wr && gain_access_enable;
    endsequence

    sequence data_step_s(logic [7:0] idx);
        res_low_wr && gain_access_enable && gain_addr_ff == idx;
    endsequence

    high_byte_write_a: assert property ( // R9
        data_step_s(`AGIA_GAIN_HIGH_IDX) |=> gain_word_o[11:4] == $past(sfr_wdata_i))
        else $error("gain high byte not written");

    low_nibble_write_a: assert property ( // R10
        data_step_s(`AGIA_GAIN_LOW_IDX) |=> gain_word_o[3:0] == $past(sfr_wdata_i[7:4]))
        else $error("gain low nibble not written");

    extra_bit_write_a: assert property ( // R12
        data_step_s(`AGIA_GAIN_EXTRA_IDX) |=> extra_sixtyfourth_bit_o == $past(sfr_wdata_i[0]))
        else $error("extra gain bit not written");

    address_capture_a: assert property ( // R5
        addr_step_s |=> gain_addr_ff == $past(sfr_wdata_i))
        else $error("gain index not captured from result high write");

    blocked_access_a: assert property ( // R4
        (sfr_wr_i && !gain_access_enable) |=> $stable(gain_word_o) && $stable(extra_sixtyfourth_bit_o))
        else $error("gain changed outside gain access");

    result_kept_a: assert property ( // R4
        (res_low_wr && gain_access_enable && !conv_done_i) |=> $stable(result_low_register_ff))
        else $error("result low written during gain access");

    gain_sum_a: assert property ( // R3
        ##1 effective_gain_o == {1'b0, $past(gain_word_o)}
            + ($past(extra_sixtyfourth_bit_o) ? `AGIA_EXTRA_WEIGHT : 13'h0000))
        else $error("effective gain mismatch");

    gain_range_a: assert property ( // R2
        effective_gain_o <= `AGIA_GAIN_MAX)
        else $error("effective gain above range");

    no_readback_a: assert property ( // R6
        (sfr_rd_i && sfr_addr_i == `AGIA_RES_LOW_ADDR) |=> sfr_rdata_o == $past(result_low_register_ff))
        else $error("read did not return result low");

    extra_reset_a: assert property ( // R13
        $rose(arst_n_i) |-> extra_sixtyfourth_bit_o)
        else $error("extra bit not set after reset");

endmodule

// File: bench/tb_agia_top.sv
// Self-checking bench of the converter gain access block.
// Assumes the design files and agia_cfg.svh are on the include path.
`timescale 1ns/10ps
`include "agia_cfg.svh"

module tb_agia_top
    import agia_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals and design
    // ----------------------------------------------------------------
    logic ref_clk_i;
    logic arst_n_i;
    logic [7:0] sfr_addr_i;
    logic [7:0] sfr_wdata_i;
    logic sfr_wr_i;
    logic sfr_rd_i;
    logic [7:0] sfr_rdata_o;
    logic conv_done_i;
    logic [15:0] conv_result_i;
    agia_word_t gain_word_o;
    logic extra_sixtyfourth_bit_o;
    logic [12:0] effective_gain_o;
    logic gain_access_enable_o;
    int error_cnt;
    int checks_done;
    integer seed;

    agia_top dut_u (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .sfr_addr_i(sfr_addr_i),
        .sfr_wdata_i(sfr_wdata_i),
        .sfr_wr_i(sfr_wr_i),
        .sfr_rd_i(sfr_rd_i),
        .sfr_rdata_o(sfr_rdata_o),
        .conv_done_i(conv_done_i),
        .conv_result_i(conv_result_i),
        .gain_word_o(gain_word_o),
        .extra_sixtyfourth_bit_o(extra_sixtyfourth_bit_o),
        .effective_gain_o(effective_gain_o),
        .gain_access_enable_o(gain_access_enable_o)
    );

    // ----------------------------------------------------------------
    // Tasks and functions
    // ----------------------------------------------------------------
    // Compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Counts line, verdict, end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Numerator over 4096 of the equivalent gain
    function automatic logic [15:0] exp_eff(input logic [11:0] w, input logic e);
        return {4'h0, w} + (e ? 16'h0040 : 16'h0000);
    endfunction

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        sfr_addr_i <= a;
        sfr_wdata_i <= d;
        sfr_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        sfr_wr_i <= 1'b0;
    endtask

    // One-cycle read strobe, data taken a cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        sfr_addr_i <= a;
        sfr_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        sfr_rd_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        d = sfr_rdata_o;
    endtask

    // Full gain session: enable, three index and data pairs, disable
    task automatic session(input logic [7:0] h, input logic [3:0] l, input logic e);
        wr(`AGIA_CFG_ADDR, 8'h01);
        wr(`AGIA_RES_HIGH_ADDR, `AGIA_GAIN_HIGH_IDX);
        wr(`AGIA_RES_LOW_ADDR, h);
        wr(`AGIA_RES_HIGH_ADDR, `AGIA_GAIN_LOW_IDX);
        wr(`AGIA_RES_LOW_ADDR, {l, 4'h0});
        wr(`AGIA_RES_HIGH_ADDR, `AGIA_GAIN_EXTRA_IDX);
        wr(`AGIA_RES_LOW_ADDR, {7'h00, e});
        check("enable", {15'h0000, gain_access_enable_o}, 16'h0001);
        wr(`AGIA_CFG_ADDR, `AGIA_CFG_RST);
        repeat (3) @(posedge ref_clk_i);
        #1;
    endtask

    // ----------------------------------------------------------------
    // Clock and watchdog
    // ----------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        error_cnt++;
        test_done();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] rv;
        logic [7:0] h;
        logic [3:0] l;
        logic e;
        logic [15:0] w;
        error_cnt = 0;
        checks_done = 0;
        seed = 91526;
        arst_n_i = 1'b0;
        sfr_addr_i = 8'h00;
        sfr_wdata_i = 8'h00;
        sfr_wr_i = 1'b0;
        sfr_rd_i = 1'b0;
        conv_done_i = 1'b0;
        conv_result_i = 16'h0000;
        repeat (5) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        #1;
        // Reset state of the gain store
        check("word", {4'h0, gain_word_o}, 16'h0fc0);
        check("extra", {15'h0000, extra_sixtyfourth_bit_o}, 16'h0001);
        check("eff", {3'h0, effective_gain_o}, 16'h1000);
        check("enable", {15'h0000, gain_access_enable_o}, 16'h0000);
        rd(`AGIA_CFG_ADDR, rv);
        check("cfg", {8'h00, rv}, 16'h00f8);
        // Load a conversion result before gain access
        @(posedge ref_clk_i);
        conv_done_i <= 1'b1;
        conv_result_i <= 16'h1234;
        @(posedge ref_clk_i);
        conv_done_i <= 1'b0;
        // Corner gains then random ones
        for (int i = 0; i < 40; i++) begin
            case (i)
                0: begin h = 8'h6c; l = 4'ha; e = 1'b1; end
                1: begin h = 8'hff; l = 4'hf; e = 1'b1; end
                2: begin h = 8'h00; l = 4'h0; e = 1'b0; end
                3: begin h = 8'hff; l = 4'hf; e = 1'b0; end
                default: begin
                    w = 16'($random(seed));
                    h = w[7:0];
                    l = w[11:8];
                    e = w[12];
                end
            endcase
            session(h, l, e);
            check("word", {4'h0, gain_word_o}, {4'h0, h, l});
            check("extra", {15'h0000, extra_sixtyfourth_bit_o}, {15'h0000, e});
            check("eff", {3'h0, effective_gain_o}, exp_eff({h, l}, e));
            check("eff_max", {15'h0000, effective_gain_o <= 13'h103f}, 16'h0001);
        end
        // Unknown index leaves the store alone
        wr(`AGIA_CFG_ADDR, 8'h01);
        wr(`AGIA_RES_HIGH_ADDR, 8'h05);
        wr(`AGIA_RES_LOW_ADDR, 8'h11);
        wr(`AGIA_CFG_ADDR, `AGIA_CFG_RST);
        repeat (2) @(posedge ref_clk_i);
        #1;
        check("word_idx", {4'h0, gain_word_o}, {4'h0, h, l});
        // Result registers untouched by gain access, gain not readable
        rd(`AGIA_RES_HIGH_ADDR, rv);
        check("res_high", {8'h00, rv}, 16'h0012);
        rd(`AGIA_RES_LOW_ADDR, rv);
        check("res_low", {8'h00, rv}, 16'h0034);
        rd(`AGIA_GAIN_HIGH_IDX, rv);
        check("gain_read", {8'h00, rv}, 16'h0000);
        // Normal write with access disabled
        wr(`AGIA_RES_LOW_ADDR, 8'h55);
        rd(`AGIA_RES_LOW_ADDR, rv);
        check("res_low_wr", {8'h00, rv}, 16'h0055);
        check("word_off", {4'h0, gain_word_o}, {4'h0, h, l});
        // Clear the extra bit, then reset in mid-run brings back the defaults
        session(8'h12, 4'h3, 1'b0);
        check("extra_clr", {15'h0000, extra_sixtyfourth_bit_o}, 16'h0000);
        arst_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1;
        check("word_rst", {4'h0, gain_word_o}, 16'h0fc0);
        check("extra_rst", {15'h0000, extra_sixtyfourth_bit_o}, 16'h0001);
        check("eff_rst", {3'h0, effective_gain_o}, 16'h1000);
        test_done();
    end
endmodule
